// ===== rtl/esb_pkg.sv
package esb_pkg;

  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;

  // Flash command codes and unlock addresses (word addresses)
  localparam logic [15:0] CMD_UNLOCK1     = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2     = 16'h0055;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP_ERASE  = 16'h0010;
  localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0030;
  localparam logic [15:0] CMD_SUSPEND     = 16'h00b0;
  localparam logic [15:0] CMD_RESUME      = 16'h0030;
  localparam logic [15:0] CMD_READ_RESET  = 16'h00f0;
  localparam logic [15:0] CMD_BLANK_CHECK = 16'h00eb;
  localparam logic [15:0] CMD_BLANK_CONF  = 16'h0076;
  localparam logic [15:0] CMD_EXIT_BYP1   = 16'h0090;
  localparam logic [15:0] CMD_EXIT_BYP2   = 16'h0000;
  localparam logic [15:0] CMD_EXIT_EXT    = 16'h0090;
  localparam logic [15:0] CMD_AUTOSEL     = 16'h0090;
  localparam logic [25:0] ADDR_UNLOCK1    = 26'h0000555;
  localparam logic [25:0] ADDR_UNLOCK2    = 26'h00002aa;
  localparam logic [25:0] ADDR_PROT_OFS   = 26'h0000002;

  // Polling bits of the device status word
  localparam int POLL_DONE_BIT = 7;
  localparam int POLL_FAIL_BIT = 5;

  // Controller register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;

  // Control word fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_HV_BIT  = 4;
  localparam int CTRL_WP_BIT  = 5;
  localparam int CTRL_BYP_BIT = 6;
  localparam int CTRL_EXT_BIT = 7;

  // Bus timing: 250 MHz system clock
  localparam int CLK_PS     = 4000;
  localparam int T_WE_NS    = 50;
  localparam int T_RD_NS    = 110;
  localparam int WE_CYC     = (T_WE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_CYC     = (T_RD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W      = 8;

  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_BERASE  = 4'h1,
    OP_CERASE  = 4'h2,
    OP_SUSPEND = 4'h3,
    OP_RESUME  = 4'h4,
    OP_BLANK   = 4'h5,
    OP_RESET   = 4'h6,
    OP_PROTRD  = 4'h7
  } esb_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_GAP   = 3'b010,
    ST_POLL  = 3'b011,
    ST_READ  = 3'b100,
    ST_DONE  = 3'b101
  } esb_state_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [25:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe_n;
  } esb_pins_t;

  typedef struct packed {
    logic [25:0] addr;
    logic [15:0] data;
  } esb_cycle_t;

endpackage : esb_pkg

// ===== rtl/esb_host.sv
// The register offsets and the strobed register port were chosen for this implementation.
module esb_host #(
  parameter int POLL_LIMIT = 4000
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  NRST,
  input  wire logic                  CE,
  input  wire logic [3:0]            ADDR,
  input  wire logic [31:0]           WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [31:0]           RDATA,
  output logic                       F_CE_N,
  output logic                       F_OE_N,
  output logic                       F_WE_N,
  output logic      [25:0]           F_ADDR,
  output logic      [15:0]           F_DQ_O,
  output logic                       F_DQ_OE_N,
  input  wire logic [15:0]           F_DQ_I,
  output logic                       F_HV_EN,
  output logic                       F_WP_HIGH
);

  esb_pkg::esb_state_t state_reg;
  esb_pkg::esb_op_t    op_reg;
  esb_pkg::esb_cycle_t seq [0:5];
  logic [2:0]          seq_len_reg;
  logic [2:0]          seq_idx_reg;
  logic [esb_pkg::CNT_W-1:0] cnt_reg;
  logic [31:0]         poll_cnt_reg;
  logic [25:0]         tgt_reg;
  logic [7:0]          ctrl_reg;
  logic                busy_reg;
  logic                fail_reg;
  logic                timeout_reg;
  logic                susp_reg;
  logic                chip_run_reg;
  logic                err_hold_reg;
  logic                refused_reg;
  logic [15:0]         rdata_word_reg;
  logic                suspend_ok;
  logic                resume_ok;
  logic                start;
  esb_pkg::esb_op_t    req_op;
  logic                byp;

  assign req_op = esb_pkg::esb_op_t'(WDATA[3:0]);
  // Bypass from high voltage shortens erase to two writes
  assign byp = ctrl_reg[esb_pkg::CTRL_HV_BIT] | ctrl_reg[esb_pkg::CTRL_BYP_BIT];
  // Chip erase cannot be suspended; request refused and flagged
  assign suspend_ok = busy_reg & (op_reg == esb_pkg::OP_BERASE) & ~chip_run_reg;
  // Resume only once bypass/extended modes left and no error pending
  // Flags of the resume write itself; the stored word lags one cycle
  assign resume_ok = susp_reg & ~busy_reg & ~err_hold_reg
                   & ~WDATA[esb_pkg::CTRL_BYP_BIT]
                   & ~WDATA[esb_pkg::CTRL_EXT_BIT];
  assign start = CE & WR & (ADDR == esb_pkg::REG_CTRL) & (state_reg == esb_pkg::ST_IDLE);

  // Command cycle table built from op and mode
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      seq[i] = '{addr: esb_pkg::ADDR_UNLOCK1, data: esb_pkg::CMD_READ_RESET};
    end
    unique case (op_reg)
      esb_pkg::OP_BERASE, esb_pkg::OP_CERASE: begin
        if (byp) begin
          seq[0] = '{addr: tgt_reg, data: esb_pkg::CMD_ERASE_SETUP};
          seq[1] = '{addr: tgt_reg, data: (op_reg == esb_pkg::OP_CERASE) ?
                     esb_pkg::CMD_CHIP_ERASE : esb_pkg::CMD_BLOCK_ERASE};
        end else begin
          seq[0] = '{addr: esb_pkg::ADDR_UNLOCK1, data: esb_pkg::CMD_UNLOCK1};
          seq[1] = '{addr: esb_pkg::ADDR_UNLOCK2, data: esb_pkg::CMD_UNLOCK2};
          seq[2] = '{addr: esb_pkg::ADDR_UNLOCK1, data: esb_pkg::CMD_ERASE_SETUP};
          seq[3] = '{addr: esb_pkg::ADDR_UNLOCK1, data: esb_pkg::CMD_UNLOCK1};
          seq[4] = '{addr: esb_pkg::ADDR_UNLOCK2, data: esb_pkg::CMD_UNLOCK2};
          seq[5] = '{addr: (op_reg == esb_pkg::OP_CERASE) ? esb_pkg::ADDR_UNLOCK1 : tgt_reg,
                     data: (op_reg == esb_pkg::OP_CERASE) ?
                     esb_pkg::CMD_CHIP_ERASE : esb_pkg::CMD_BLOCK_ERASE};
        end
      end
      esb_pkg::OP_SUSPEND: seq[0] = '{addr: tgt_reg, data: esb_pkg::CMD_SUSPEND};
      esb_pkg::OP_RESUME:  seq[0] = '{addr: tgt_reg, data: esb_pkg::CMD_RESUME};
      esb_pkg::OP_BLANK: begin
        seq[0] = '{addr: tgt_reg, data: esb_pkg::CMD_BLANK_CHECK};
        seq[1] = '{addr: tgt_reg, data: esb_pkg::CMD_BLANK_CONF};
      end
      esb_pkg::OP_PROTRD: begin
        seq[0] = '{addr: esb_pkg::ADDR_UNLOCK1, data: esb_pkg::CMD_UNLOCK1};
        seq[1] = '{addr: esb_pkg::ADDR_UNLOCK2, data: esb_pkg::CMD_UNLOCK2};
        seq[2] = '{addr: esb_pkg::ADDR_UNLOCK1, data: esb_pkg::CMD_AUTOSEL};
      end
      default: ;
    endcase
  end

  // Control word; mode bits steer bypass and the high-voltage/protect pins
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ctrl_reg <= 8'h00;
      tgt_reg  <= 26'h0000000;
    end else if (CE && WR) begin
      if (ADDR == esb_pkg::REG_CTRL) begin
        ctrl_reg <= WDATA[7:0];
      end else if (ADDR == esb_pkg::REG_ADDR) begin
        tgt_reg <= WDATA[25:0];
      end
    end
  end

  // Pin levels: high voltage only while a chip erase runs
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      F_HV_EN   <= 1'b0;
      F_WP_HIGH <= 1'b0;
    end else if (CE) begin
      // Raised before the command writes so the device is in bypass
      F_HV_EN   <= (start & (req_op == esb_pkg::OP_CERASE) & WDATA[esb_pkg::CTRL_HV_BIT])
                   | (ctrl_reg[esb_pkg::CTRL_HV_BIT] & (state_reg != esb_pkg::ST_IDLE)
                      & (op_reg == esb_pkg::OP_CERASE));
      F_WP_HIGH <= ctrl_reg[esb_pkg::CTRL_WP_BIT];
    end
  end

  // Sequencer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_reg    <= esb_pkg::ST_IDLE;
      op_reg       <= esb_pkg::OP_NONE;
      seq_idx_reg  <= 3'h0;
      seq_len_reg  <= 3'h0;
      cnt_reg      <= '0;
      poll_cnt_reg <= 32'h00000000;
      busy_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      timeout_reg  <= 1'b0;
      refused_reg  <= 1'b0;
      // Suspend forgotten on reset; software must re-erase that block
      susp_reg     <= 1'b0;
      chip_run_reg <= 1'b0;
      err_hold_reg <= 1'b0;
      rdata_word_reg <= 16'h0000;
      F_CE_N       <= 1'b1;
      F_OE_N       <= 1'b1;
      F_WE_N       <= 1'b1;
      F_ADDR       <= 26'h0000000;
      F_DQ_O       <= 16'h0000;
      F_DQ_OE_N    <= 1'b1;
    end else if (CE) begin
      unique case (state_reg)
        esb_pkg::ST_IDLE: begin
          if (start) begin
            refused_reg <= 1'b0;
            op_reg      <= req_op;
            seq_idx_reg <= 3'h0;
            // Suspend/resume gated by suspend_ok/resume_ok; OP_NONE dropped
            if ((req_op == esb_pkg::OP_SUSPEND && !suspend_ok) ||
                (req_op == esb_pkg::OP_RESUME && !resume_ok) ||
                (req_op == esb_pkg::OP_NONE)) begin
              refused_reg <= (req_op != esb_pkg::OP_NONE);
            end else begin
              unique case (req_op)
                esb_pkg::OP_BERASE, esb_pkg::OP_CERASE:
                  // Table follows the new control word; length must too
                  seq_len_reg <= (WDATA[esb_pkg::CTRL_HV_BIT] | WDATA[esb_pkg::CTRL_BYP_BIT]) ?
                                 3'h2 : 3'h6;
                esb_pkg::OP_BLANK: seq_len_reg <= 3'h2;
                esb_pkg::OP_PROTRD: seq_len_reg <= 3'h3;
                default: seq_len_reg <= 3'h1;
              endcase
              state_reg <= esb_pkg::ST_WRITE;
              cnt_reg   <= '0;
              if (req_op == esb_pkg::OP_RESET) begin
                err_hold_reg <= 1'b0;
                fail_reg     <= 1'b0;
              end
            end
          end
        end
        esb_pkg::ST_WRITE: begin
          F_CE_N    <= 1'b0;
          F_WE_N    <= 1'b0;
          F_DQ_OE_N <= 1'b0;
          F_ADDR    <= seq[seq_idx_reg].addr;
          F_DQ_O    <= seq[seq_idx_reg].data;
          cnt_reg   <= cnt_reg + 1'b1;
          if (cnt_reg == esb_pkg::CNT_W'(esb_pkg::WE_CYC)) begin
            F_WE_N    <= 1'b1;
            cnt_reg   <= '0;
            state_reg <= esb_pkg::ST_GAP;
          end
        end
        esb_pkg::ST_GAP: begin
          F_DQ_OE_N <= 1'b1;
          F_CE_N    <= 1'b1;
          if (seq_idx_reg + 3'h1 < seq_len_reg) begin
            seq_idx_reg <= seq_idx_reg + 3'h1;
            state_reg   <= esb_pkg::ST_WRITE;
          end else begin
            unique case (op_reg)
              esb_pkg::OP_BERASE, esb_pkg::OP_CERASE, esb_pkg::OP_BLANK: begin
                busy_reg     <= 1'b1;
                chip_run_reg <= (op_reg == esb_pkg::OP_CERASE);
                poll_cnt_reg <= 32'h00000000;
                state_reg    <= esb_pkg::ST_POLL;
              end
              esb_pkg::OP_SUSPEND: begin
                susp_reg  <= 1'b1;
                busy_reg  <= 1'b0;
                state_reg <= esb_pkg::ST_IDLE;
              end
              esb_pkg::OP_RESUME: begin
                susp_reg     <= 1'b0;
                busy_reg     <= 1'b1;
                op_reg       <= esb_pkg::OP_BERASE;
                poll_cnt_reg <= 32'h00000000;
                state_reg    <= esb_pkg::ST_POLL;
              end
              esb_pkg::OP_PROTRD: begin
                F_ADDR    <= tgt_reg | esb_pkg::ADDR_PROT_OFS;
                state_reg <= esb_pkg::ST_READ;
              end
              default: state_reg <= esb_pkg::ST_IDLE;
            endcase
          end
        end
        esb_pkg::ST_POLL: begin
          // Any read during erase/blank check gives the polling word
          F_CE_N  <= 1'b0;
          F_OE_N  <= 1'b0;
          F_ADDR  <= tgt_reg;
          cnt_reg <= cnt_reg + 1'b1;
          // Suspend is the one request taken while not idle
          if (WR && ADDR == esb_pkg::REG_CTRL &&
              req_op == esb_pkg::OP_SUSPEND && !suspend_ok) begin
            refused_reg <= 1'b1;
          end
          if (WR && ADDR == esb_pkg::REG_CTRL &&
              req_op == esb_pkg::OP_SUSPEND && suspend_ok) begin
            F_OE_N    <= 1'b1;
            op_reg    <= esb_pkg::OP_SUSPEND;
            seq_len_reg <= 3'h1;
            seq_idx_reg <= 3'h0;
            cnt_reg   <= '0;
            state_reg <= esb_pkg::ST_WRITE;
          end else if (cnt_reg == esb_pkg::CNT_W'(esb_pkg::RD_CYC)) begin
            cnt_reg        <= '0;
            F_OE_N         <= 1'b1;
            rdata_word_reg <= F_DQ_I;
            poll_cnt_reg   <= poll_cnt_reg + 32'h00000001;
            if (F_DQ_I[esb_pkg::POLL_DONE_BIT]) begin
              busy_reg     <= 1'b0;
              chip_run_reg <= 1'b0;
              state_reg    <= esb_pkg::ST_DONE;
            end else if (F_DQ_I[esb_pkg::POLL_FAIL_BIT]) begin
              // Failed blocks or non-blank block: device holds error
              fail_reg     <= 1'b1;
              err_hold_reg <= 1'b1;
              busy_reg     <= 1'b0;
              chip_run_reg <= 1'b0;
              state_reg    <= esb_pkg::ST_DONE;
            end else if (poll_cnt_reg == POLL_LIMIT) begin
              timeout_reg <= 1'b1;
              busy_reg    <= 1'b0;
              state_reg   <= esb_pkg::ST_DONE;
            end
          end
        end
        esb_pkg::ST_READ: begin
          F_OE_N  <= 1'b0;
          F_CE_N  <= 1'b0;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == esb_pkg::CNT_W'(esb_pkg::RD_CYC)) begin
            rdata_word_reg <= F_DQ_I;
            cnt_reg        <= '0;
            op_reg         <= esb_pkg::OP_RESET;
            seq_len_reg    <= 3'h1;
            seq_idx_reg    <= 3'h0;
            F_OE_N         <= 1'b1;
            state_reg      <= esb_pkg::ST_WRITE;
          end
        end
        esb_pkg::ST_DONE: begin
          F_CE_N    <= 1'b1;
          F_OE_N    <= 1'b1;
          state_reg <= esb_pkg::ST_IDLE;
        end
        default: state_reg <= esb_pkg::ST_IDLE;
      endcase
    end
  end

  // Register read port, data one cycle later
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      RDATA <= 32'h00000000;
    end else if (CE && RD) begin
      unique case (ADDR)
        esb_pkg::REG_CTRL:   RDATA <= {24'h000000, ctrl_reg};
        esb_pkg::REG_ADDR:   RDATA <= {6'h00, tgt_reg};
        esb_pkg::REG_STATUS: RDATA <= {24'h000000, susp_reg, chip_run_reg, err_hold_reg,
                                       refused_reg, timeout_reg, fail_reg,
                                       state_reg != esb_pkg::ST_IDLE, busy_reg};
        esb_pkg::REG_RDATA:  RDATA <= {16'h0000, rdata_word_reg};
        default:             RDATA <= 32'h00000000;
      endcase
    end
  end

endmodule : esb_host

// ===== bench/esb_host_sva.sv
module esb_host_sva (
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        F_CE_N,
  input wire logic        F_OE_N,
  input wire logic        F_WE_N,
  input wire logic        F_DQ_OE_N,
  input wire logic        F_HV_EN
);
  localparam int WE_LEN = esb_pkg::WE_CYC;
  logic [7:0] we_cnt_reg;
  logic       hv_ok_reg;
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Suspend writes skipped: they must not clear the chip erase grant
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) hv_ok_reg <= 1'b0;
    else if (WR && ADDR == esb_pkg::REG_CTRL && WDATA[3:0] != 4'h3)
      hv_ok_reg <= WDATA[3:0] == 4'h2 && WDATA[4];
  end
  always_ff @(posedge CLK_SYS) begin
    if (!NRST || F_WE_N) we_cnt_reg <= 8'h00;
    else we_cnt_reg <= we_cnt_reg + 8'h01;
  end
  sequence s_ctrl_wr;
    WR && ADDR == esb_pkg::REG_CTRL;
  endsequence
  sequence s_bad_resume;
    s_ctrl_wr ##0 (WDATA[3:0] == 4'h4 && WDATA[7:6] != 2'b00);
  endsequence
  a_hv_chip_only: assert property (F_HV_EN |-> hv_ok_reg)
    else $error("high voltage outside chip erase");
  a_resume_blocked: assert property (s_bad_resume |=> (F_WE_N && F_OE_N) [*8])
    else $error("resume sent with mode flags set");
  a_we_pulse_len: assert property ($rose(F_WE_N) |-> we_cnt_reg == WE_LEN)
    else $error("write pulse length wrong");
  a_write_gap: assert property ($rose(F_WE_N) |=> F_WE_N)
    else $error("no gap after write");
  a_we_drives_bus: assert property (!F_WE_N |-> !F_CE_N && !F_DQ_OE_N && F_OE_N)
    else $error("write without bus drive");
  a_no_contention: assert property (!F_OE_N |-> F_DQ_OE_N)
    else $error("bus driven during read");
  a_reset_quiet: assert property ($rose(NRST) |-> F_CE_N && F_WE_N && F_DQ_OE_N
                                  && !F_HV_EN && RDATA == 32'h0)
    else $error("outputs not idle after reset");
  a_rdata_hold: assert property (!$past(RD) |-> $stable(RDATA))
    else $error("read data moved without read");
endmodule : esb_host_sva

bind esb_host esb_host_sva i_sva (.CLK_SYS(CLK_SYS), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .F_CE_N(F_CE_N), .F_OE_N(F_OE_N), .F_WE_N(F_WE_N),
  .F_DQ_OE_N(F_DQ_OE_N), .F_HV_EN(F_HV_EN));

// ===== bench/esb_flash_model.sv
module esb_flash_model #(
  parameter int ERASE_CYC = 80
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [25:0] addr,
  input  wire logic [15:0] dq_o,
  input  wire logic        hv,
  input  wire logic        wp,
  output logic      [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wd_reg, pre_reg, word;
  logic [1:0]  wb_reg, blk_reg, kind_reg, unl_reg;
  logic [3:0]  blank_reg;
  logic        we_d_reg, err_reg, susp_reg, auto_reg;
  int          cnt_reg;
  function automatic logic guarded(input logic [1:0] b);
    return b == 2'd0 && !wp && !hv;
  endfunction : guarded
  always_comb begin
    if (auto_reg) word = {15'h0, addr[1:0] == 2'd2 && guarded(addr[17:16])};
    else if (cnt_reg != 0 || err_reg || (susp_reg && addr[17:16] == blk_reg))
      word = {8'h00, (cnt_reg == 0 && !err_reg) || susp_reg, 1'b0, err_reg, 5'h00};
    else word = blank_reg[addr[17:16]] ? 16'hffff : 16'h3c80;
  end
  // Released bus inverts each cycle, showing the stale word every other cycle
  always_ff @(posedge clk) begin
    if (!rst_n) dq_i <= 16'h0;
    else dq_i <= (!ce_n && !oe_n) ? word : ~dq_i;
  end
  always_ff @(posedge clk) begin
    we_d_reg <= we_n;
    if (!we_n && !ce_n) begin
      wd_reg <= dq_o;
      wb_reg <= addr[17:16];
    end
    if (!rst_n) begin
      cnt_reg   <= 0;
      err_reg   <= 1'b0;
      susp_reg  <= 1'b0;
      auto_reg  <= 1'b0;
      unl_reg   <= 2'd0;
      pre_reg   <= 16'h0;
      blank_reg <= 4'h0;
    end else if (we_n && !we_d_reg) begin
      unl_reg  <= wd_reg == 16'h00aa ? 2'd1 : (wd_reg == 16'h0055 && unl_reg == 2'd1) ? 2'd2 : 2'd0;
      pre_reg  <= (wd_reg == 16'h00aa || wd_reg == 16'h0055) ? pre_reg : wd_reg;
      auto_reg <= wd_reg == 16'h0090 || (auto_reg && unl_reg != 2'd0);
      if (cnt_reg != 0 && !susp_reg) begin
        if (wd_reg == 16'h00b0 && kind_reg == 2'd1) susp_reg <= 1'b1;
      end else if (wd_reg == 16'h00f0) err_reg <= 1'b0;
      else if (wd_reg == 16'h0030 && pre_reg != 16'h0080) begin
        if (!auto_reg && !err_reg) susp_reg <= 1'b0;
      end else if (pre_reg == 16'h0080 && (unl_reg == 2'd2 || hv) && !err_reg) begin
        if (wd_reg == 16'h0010) begin
          kind_reg <= 2'd2;
          cnt_reg  <= ERASE_CYC;
        end else if (wd_reg == 16'h0030 && !guarded(wb_reg)) begin
          kind_reg <= 2'd1;
          blk_reg  <= wb_reg;
          cnt_reg  <= blank_reg[wb_reg] ? 8 : ERASE_CYC;
        end
      end else if (pre_reg == 16'h00eb && wd_reg == 16'h0076) begin
        kind_reg <= 2'd3;
        blk_reg  <= wb_reg;
        cnt_reg  <= 20;
      end
    end else if (cnt_reg != 0 && !susp_reg) begin
      cnt_reg <= cnt_reg - 1;
      // Block 2 is defective: it never erases
      if (cnt_reg == 1) begin
        for (int b = 0; b < 4; b++)
          if (b != 2 && ((kind_reg == 2'd2 && !guarded(2'(b))) || (kind_reg == 2'd1 && blk_reg == 2'(b))))
            blank_reg[b] <= 1'b1;
        err_reg <= kind_reg == 2'd3 ? !blank_reg[blk_reg] : (kind_reg == 2'd2 || blk_reg == 2'd2);
      end
    end
  end
endmodule : esb_flash_model

// ===== bench/esb_host_tb.sv
module esb_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd_val;
  logic        ce_n, oe_n, we_n, dq_oe_n, hv_en, wp_high;
  logic [25:0] f_addr;
  logic [15:0] dq_o, dq_i;
  logic [15:0] lfsr = 16'h34d2;
  logic [3:0]  op;
  int          err_total = 0;
  int          samples_checked = 0;
  initial forever #2 clk = ~clk;
  esb_host #(.POLL_LIMIT(5)) i_dut (.CLK_SYS(clk), .NRST(nrst), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .F_CE_N(ce_n), .F_OE_N(oe_n),
    .F_WE_N(we_n), .F_ADDR(f_addr), .F_DQ_O(dq_o), .F_DQ_OE_N(dq_oe_n), .F_DQ_I(dq_i),
    .F_HV_EN(hv_en), .F_WP_HIGH(wp_high));
  esb_flash_model i_flash (.clk(clk), .rst_n(nrst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(f_addr), .dq_o(dq_o), .hv(hv_en), .wp(wp_high), .dq_i(dq_i));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // Only block 2 is left unerased once the chip erase has run
  function automatic logic exp_res(input logic [3:0] o, input logic [1:0] b, input logic w);
    return (o == 4'h7) ? (b == 2'd0 && !w) : (b == 2'd2);
  endfunction : exp_res
  task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rd_val = rdata;
  endtask : reg_rd
  task automatic stat(input string what, input int b, input logic e);
    reg_rd(esb_pkg::REG_STATUS);
    chk(what, {31'h0, e}, {31'h0, rd_val[b]});
  endtask : stat
  task automatic go(input logic [3:0] o, input logic [1:0] b, input logic [3:0] flg);
    reg_wr(esb_pkg::REG_ADDR, {14'h0, b, 16'h0});
    reg_wr(esb_pkg::REG_CTRL, {24'h0, flg, o});
  endtask : go
  task automatic wait_idle;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 2000; i++) begin
      reg_rd(esb_pkg::REG_STATUS);
      if (rd_val[1] === 1'b0) return;
    end
    err_total++;
    give_verdict;
  endtask : wait_idle
  task automatic wait_poll;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (oe_n === 1'b0) return;
    end
    err_total++;
    give_verdict;
  endtask : wait_poll
  task automatic op_idle(input logic [3:0] o, input logic [1:0] b, input logic [3:0] flg);
    go(o, b, flg);
    wait_idle;
  endtask : op_idle
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    op_idle(4'h1, 2'd1, 4'h2);
    op_idle(4'h5, 2'd1, 4'h2);
    stat("fail", 2, 1'b0);
    op_idle(4'h1, 2'd0, 4'h0);
    op_idle(4'h5, 2'd0, 4'h0);
    stat("fail", 2, 1'b1);
    stat("hold", 5, 1'b1);
    op_idle(4'h6, 2'd0, 4'h0);
    stat("hold", 5, 1'b0);
    go(4'h1, 2'd3, 4'h2);
    repeat (2) begin
      wait_poll;
      op_idle(4'h3, 2'd3, 4'h2);
      stat("suspended", 7, 1'b1);
      go(4'h4, 2'd3, 4'h6);
      stat("refused", 4, 1'b1);
      stat("suspended", 7, 1'b1);
      go(4'h4, 2'd3, 4'h2);
    end
    wait_idle;
    stat("suspended", 7, 1'b0);
    stat("fail", 2, 1'b0);
    go(4'h2, 2'd0, 4'h1);
    wait_poll;
    go(4'h3, 2'd0, 4'h1);
    stat("refused", 4, 1'b1);
    stat("chip_run", 6, 1'b1);
    wait_idle;
    stat("fail", 2, 1'b1);
    chk("hv_en", 32'h0, {31'h0, hv_en});
    op_idle(4'h6, 2'd0, 4'h0);
    repeat (12) begin
      lfsr = nxt(lfsr);
      op = (lfsr[1:0] == 2'd0) ? 4'h7 : lfsr[2] ? 4'h1 : 4'h5;
      op_idle(op, lfsr[4:3], {2'b0, lfsr[5], 1'b0});
      if (op == 4'h7) reg_rd(esb_pkg::REG_RDATA);
      else reg_rd(esb_pkg::REG_STATUS);
      chk("result", {31'h0, exp_res(op, lfsr[4:3], lfsr[5])}, {31'h0, rd_val[(op == 4'h7) ? 0 : 2]});
      op_idle(4'h6, 2'd0, 4'h0);
    end
    stat("timeout", 3, 1'b0);
    give_verdict;
  end
endmodule : esb_host_tb
